/* File: verilog/fpa_pkg.sv */
// Constants and types shared by the flash access and security block.
// Assumes a single core clock domain and a synchronous reset.
`default_nettype none
package fpa_pkg;
	// Parallel operation select codes, bits 4..1
	localparam logic [3:0] OP_ERASE = 4'h0;
	localparam logic [3:0] OP_SIG = 4'h9;
	localparam logic [3:0] OP_PCODE = 4'ha;
	localparam logic [3:0] OP_PDATA = 4'h2;
	localparam logic [3:0] OP_RCODE = 4'hb;
	localparam logic [3:0] OP_RDATA = 4'h3;
	localparam logic [3:0] OP_PSEC = 4'hc;
	localparam logic [3:0] OP_RSEC = 4'hd;
	// Flash command register codes
	localparam logic [7:0] CMD_READ = 8'h01;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_VERIFY = 8'h04;
	localparam logic [7:0] CMD_ERPAGE = 8'h05;
	localparam logic [7:0] CMD_ERALL = 8'h06;
	localparam logic [7:0] CMD_RDBYTE = 8'h81;
	localparam logic [7:0] CMD_WRBYTE = 8'h82;
	localparam logic [7:0] CMD_LEAVE_USER_DOWNLOAD_MODE = 8'h0f;
	localparam logic [7:0] CMD_USER_DOWNLOAD_MODE = 8'hf0;
	localparam logic [7:0] VERIFY_BAD = 8'h01;
	localparam logic [7:0] CMD_RESET = 8'h00;
	// Register indices in the special function space
	localparam logic [2:0] SFR_CMD = 3'h0;
	localparam logic [2:0] SFR_DATA1 = 3'h1;
	localparam logic [2:0] SFR_DATA2 = 3'h2;
	localparam logic [2:0] SFR_DATA3 = 3'h3;
	localparam logic [2:0] SFR_DATA4 = 3'h4;
	localparam logic [2:0] SFR_ADDRL = 3'h5;
	localparam logic [2:0] SFR_ADDRH = 3'h6;
	// Memory map
	localparam int PROG_BYTES = 63488;
	localparam int DATA_PAGES = 1024;
	localparam logic [15:0] PROG_END = 16'hf7ff;
	localparam logic [15:0] USER_DOWNLOAD_MODE_END = 16'hdfff;
	localparam logic [15:0] DATA_LAST_PAGE = 16'h03ff;
	localparam logic [15:0] BOOT_ADDR = 16'he000;
	localparam logic [15:0] RESET_ADDR = 16'h0000;
	localparam logic [5:0] UPAGE_MASK = 6'h3f;
	localparam logic [7:0] ERASED = 8'hff;
	// Security bit positions and reset value
	localparam int SEC_LOCK = 0;
	localparam int SEC_SECURE = 1;
	localparam int SEC_SAFE = 2;
	localparam int SEC_BOOT = 3;
	localparam logic [3:0] SEC_RESET = 4'h0;
	// Cycles after reset release before the boot pin is judged
	localparam logic [1:0] BOOT_WAIT = 2'h3;
	typedef enum logic [1:0] {ST_IDLE, ST_ERP, ST_ERD} fpa_state_t;
endpackage
`default_nettype wire

/* File: verilog/fpa_top.sv */
// Flash program/data access, parallel programming port and security locks.
// Assumes pins are asynchronous and the kernel and core are on mclk_in.
//
// Summary of operation
// - Reset with boot select pin low enters serial download mode.
// - Serial download runs the kernel, which may write all user program flash.
// - Select code picks signature, code, data or security read or program.
// - Select code 0000 erases program, data and all security settings.
// - Normal mode leaves all user program flash read-only to the core.
// - User download mode lets the core erase and write lower program flash.
// - Upper program flash is never writable by core software.
// - Bootload option starts execution at E000h after every reset.
// - Three protection modes are set independently by download or programmer.
// - Lock blocks parallel program writes, allows reads and external reads.
// - Secure also blocks parallel code reads and external code reads.
// - Lock and secure clear only on erase from serial or parallel mode.
// - Serial-safe makes a boot-select reset a normal reset.
// - Serial-safe clears only on parallel erase, never serial download.
// - Data flash is 1024 pages of four bytes.
// - Four data registers hold a page; high/low registers select it.
// - Writing the command register triggers one of nine commands.
// - Commands target data flash normally, lower program flash in user mode.
// - Command 01h loads the addressed page into the data registers.
// - Command 02h writes data registers to a pre-erased page.
// - After 04h the command register reads zero on match, else nonzero.
// - F0h enters user download mode, 0Fh returns to data flash.
`default_nettype none
module fpa_top
	import fpa_pkg::*;
#(
	parameter logic [7:0] SIGNATURE = 8'h5a // Arbitrary signature value
)
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic boot_select_pin_n_in,
	input wire logic par_mode_in,
	input wire logic [15:0] par_addr_in,
	input wire logic [7:0] parallel_data_port_in,
	input wire logic parallel_write_strobe_n_in,
	input wire logic [3:0] par_op_select_in,
	input wire logic kern_wr_in,
	input wire logic [15:0] kern_addr_in,
	input wire logic [7:0] kern_data_in,
	input wire logic kern_erase_in,
	input wire logic kern_sec_wr_in,
	input wire logic [3:0] kern_sec_in,
	input wire logic [2:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [15:0] core_fetch_addr_in,
	input wire logic core_ext_in,
	output logic [7:0] parallel_data_port_out,
	output logic parallel_data_port_oe_out,
	output logic [7:0] sfr_rdata_out,
	output logic [7:0] code_rdata_out,
	output logic serial_download_out,
	output logic [15:0] boot_vector_out,
	output logic boot_done_out,
	output logic user_download_mode_out,
	output logic flash_busy_out,
	output logic [3:0] sec_out
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] pmem [0:PROG_BYTES-1];
	logic [31:0] dmem [0:DATA_PAGES-1];
	fpa_state_t st_reg, st_next;
	logic [15:0] er_addr_reg, er_addr_next, er_end_reg, er_end_next;
	logic er_data_reg, er_data_next;
	logic [3:0] sec_reg, sec_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [31:0] edata_reg, edata_next;
	logic [7:0] addr_l_reg, addr_l_next, addr_h_reg, addr_h_next;
	logic user_download_mode_reg, user_download_mode_next, serdl_reg, serdl_next;
	logic [15:0] bootvec_reg, bootvec_next;
	logic [1:0] boot_cnt_reg, boot_cnt_next;
	logic [7:0] pdout_reg, pdout_next, sfr_rd_reg, sfr_rd_next;
	logic [7:0] code_rd_reg, code_rd_next;
	logic poe_reg, poe_next, strb_prev_reg;
	logic boot_s1, boot_s2, pm_s1, pm_s2, ws_s1, ws_s2;
	logic [3:0] op_s1, op_s2;
	logic [15:0] pa_s1, pa_s2;
	logic [7:0] pd_s1, pd_s2;
	logic pm_we, dm_we;
	logic [15:0] pm_wa;
	logic [7:0] pm_wd;
	logic [9:0] dm_wa;
	logic [31:0] dm_wd;
	logic [9:0] page, bpage;
	logic [1:0] lane;
	logic strobe;
	logic done_reg, done_next, busy_reg, busy_next;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] get_lane(input logic [31:0] w,
		input logic [1:0] s);
		get_lane = w[8*s +: 8];
	endfunction

	function automatic logic [31:0] put_lane(input logic [31:0] w,
		input logic [1:0] s, input logic [7:0] b);
		logic [31:0] r;
		r = w;
		r[8*s +: 8] = b;
		put_lane = r;
	endfunction

	function automatic logic [7:0] prog_rd(input logic [15:0] a);
		prog_rd = (a <= PROG_END) ? pmem[a] : 8'h00; // Hidden space reads 0
	endfunction

	// Page index from the address registers; byte address for byte cmds
	assign page = {addr_h_reg[1:0], addr_l_reg};
	assign bpage = {addr_h_reg[3:0], addr_l_reg[7:2]};
	assign lane = addr_l_reg[1:0];
	assign strobe = strb_prev_reg & ~ws_s2;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Two stages on every pin; no reset needed on data path
	always_ff @(posedge mclk_in)
	begin
		boot_s1 <= boot_select_pin_n_in;
		boot_s2 <= boot_s1;
		pm_s1 <= par_mode_in;
		pm_s2 <= pm_s1;
		ws_s1 <= parallel_write_strobe_n_in;
		ws_s2 <= ws_s1;
		op_s1 <= par_op_select_in;
		op_s2 <= op_s1;
		pa_s1 <= par_addr_in;
		pa_s2 <= pa_s1;
		pd_s1 <= parallel_data_port_in;
		pd_s2 <= pd_s1;
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	// Boot capture, parallel port, kernel, command register, erase engine
	always_comb
	begin
		st_next = st_reg;
		er_addr_next = er_addr_reg;
		er_end_next = er_end_reg;
		er_data_next = er_data_reg;
		sec_next = sec_reg;
		cmd_next = cmd_reg;
		edata_next = edata_reg;
		addr_l_next = addr_l_reg;
		addr_h_next = addr_h_reg;
		user_download_mode_next = user_download_mode_reg;
		serdl_next = serdl_reg;
		bootvec_next = bootvec_reg;
		boot_cnt_next = boot_cnt_reg;
		pm_we = 1'b0;
		pm_wa = 16'h0000;
		pm_wd = 8'h00;
		dm_we = 1'b0;
		dm_wa = 10'h000;
		dm_wd = 32'h00000000;
		// Boot mode judged once the pin has passed the synchroniser
		if (boot_cnt_reg != BOOT_WAIT)
		begin
			boot_cnt_next = boot_cnt_reg + 2'h1;
			if (boot_cnt_reg == BOOT_WAIT - 2'h1)
			begin
				serdl_next = ~boot_s2 & ~sec_reg[SEC_SAFE];
				bootvec_next = sec_reg[SEC_BOOT] ? BOOT_ADDR
					: RESET_ADDR;
			end
		end
		// Data and address registers are always writable
		if (sfr_wr_in)
		begin
			if (sfr_addr_in == SFR_DATA1)
				edata_next[7:0] = sfr_wdata_in;
			else if (sfr_addr_in == SFR_DATA2)
				edata_next[15:8] = sfr_wdata_in;
			else if (sfr_addr_in == SFR_DATA3)
				edata_next[23:16] = sfr_wdata_in;
			else if (sfr_addr_in == SFR_DATA4)
				edata_next[31:24] = sfr_wdata_in;
			else if (sfr_addr_in == SFR_ADDRL)
				addr_l_next = sfr_wdata_in;
			else if (sfr_addr_in == SFR_ADDRH)
				addr_h_next = sfr_wdata_in;
		end
		case (st_reg)
			ST_IDLE:
			begin
				if (pm_s2 && strobe)
				begin
					// Parallel write operations; others are reads or no-ops
					if (op_s2 == OP_ERASE)
					begin
						sec_next = SEC_RESET;
						st_next = ST_ERP;
						er_addr_next = 16'h0000;
						er_end_next = PROG_END;
						er_data_next = 1'b1;
					end
					else if (op_s2 == OP_PCODE)
					begin
						pm_we = ~(sec_reg[SEC_LOCK] | sec_reg[SEC_SECURE])
							& (pa_s2 <= PROG_END);
						pm_wa = pa_s2;
						pm_wd = pd_s2;
					end
					else if (op_s2 == OP_PDATA)
					begin
						dm_we = 1'b1;
						dm_wa = pa_s2[11:2];
						dm_wd = put_lane(dmem[pa_s2[11:2]], pa_s2[1:0], pd_s2);
					end
					else if (op_s2 == OP_PSEC)
						sec_next = sec_reg | pd_s2[3:0];
				end
				else if (serdl_reg && kern_erase_in)
				begin
					// Serial erase keeps serial-safe and bootload option
					sec_next[SEC_LOCK] = 1'b0;
					sec_next[SEC_SECURE] = 1'b0;
					st_next = ST_ERP;
					er_addr_next = 16'h0000;
					er_end_next = PROG_END;
					er_data_next = 1'b1;
				end
				else if (serdl_reg && kern_wr_in)
				begin
					pm_we = kern_addr_in <= PROG_END;
					pm_wa = kern_addr_in;
					pm_wd = kern_data_in;
				end
				else if (serdl_reg && kern_sec_wr_in)
					sec_next = sec_reg | kern_sec_in;
				else if (sfr_wr_in && sfr_addr_in == SFR_CMD)
				begin
					cmd_next = sfr_wdata_in;
					if (sfr_wdata_in == CMD_USER_DOWNLOAD_MODE)
						user_download_mode_next = 1'b1;
					else if (sfr_wdata_in == CMD_LEAVE_USER_DOWNLOAD_MODE)
						user_download_mode_next = 1'b0;
					else if (user_download_mode_reg)
					begin
						// Lower program flash only; upper stays read-only
						if (sfr_wdata_in == CMD_ERPAGE &&
							{addr_h_reg, addr_l_reg} <= USER_DOWNLOAD_MODE_END)
						begin
							st_next = ST_ERP;
							er_addr_next = {addr_h_reg, addr_l_reg & ~{2'b00,
								UPAGE_MASK}};
							er_end_next = {addr_h_reg, addr_l_reg |
								{2'b00, UPAGE_MASK}};
							er_data_next = 1'b0;
						end
						else if (sfr_wdata_in == CMD_ERALL)
						begin
							st_next = ST_ERP;
							er_addr_next = 16'h0000;
							er_end_next = USER_DOWNLOAD_MODE_END;
							er_data_next = 1'b0;
						end
						else if (sfr_wdata_in == CMD_WRBYTE)
						begin
							pm_we = {addr_h_reg, addr_l_reg} <= USER_DOWNLOAD_MODE_END;
							pm_wa = {addr_h_reg, addr_l_reg};
							pm_wd = edata_reg[7:0];
						end
					end
					else if (sfr_wdata_in == CMD_READ)
						edata_next = dmem[page];
					else if (sfr_wdata_in == CMD_WRITE)
					begin
						dm_we = 1'b1;
						dm_wa = page;
						dm_wd = edata_reg;
					end
					else if (sfr_wdata_in == CMD_VERIFY)
						cmd_next = (dmem[page] == edata_reg) ? 8'h00
							: VERIFY_BAD;
					else if (sfr_wdata_in == CMD_ERPAGE)
					begin
						dm_we = 1'b1;
						dm_wa = page;
						dm_wd = {4{ERASED}};
					end
					else if (sfr_wdata_in == CMD_ERALL)
					begin
						st_next = ST_ERD;
						er_addr_next = 16'h0000;
						er_end_next = DATA_LAST_PAGE;
					end
					else if (sfr_wdata_in == CMD_RDBYTE)
						edata_next[7:0] = get_lane(dmem[bpage], lane);
					else if (sfr_wdata_in == CMD_WRBYTE)
					begin
						dm_we = 1'b1;
						dm_wa = bpage;
						dm_wd = put_lane(dmem[bpage], lane, edata_reg[7:0]);
					end
				end
			end
			ST_ERP:
			begin
				// One program byte erased per cycle
				pm_we = 1'b1;
				pm_wa = er_addr_reg;
				pm_wd = ERASED;
				er_addr_next = er_addr_reg + 16'h0001;
				if (er_addr_reg == er_end_reg)
				begin
					st_next = er_data_reg ? ST_ERD : ST_IDLE;
					er_addr_next = 16'h0000;
					er_end_next = DATA_LAST_PAGE;
				end
			end
			ST_ERD:
			begin
				// One data page erased per cycle
				dm_we = 1'b1;
				dm_wa = er_addr_reg[9:0];
				dm_wd = {4{ERASED}};
				er_addr_next = er_addr_reg + 16'h0001;
				if (er_addr_reg == er_end_reg)
					st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
		// Status flags registered so outputs come from flops
		done_next = boot_cnt_next == BOOT_WAIT;
		busy_next = st_next != ST_IDLE;
	end

	// Read paths: parallel port, register reads, core code fetch
	always_comb
	begin
		pdout_next = 8'h00;
		poe_next = 1'b0;
		if (pm_s2)
		begin
			poe_next = 1'b1;
			if (op_s2 == OP_SIG)
				pdout_next = SIGNATURE;
			else if (op_s2 == OP_RCODE)
				pdout_next = sec_reg[SEC_SECURE] ? 8'h00
					: prog_rd(pa_s2);
			else if (op_s2 == OP_RDATA)
				pdout_next = get_lane(dmem[pa_s2[11:2]], pa_s2[1:0]);
			else if (op_s2 == OP_RSEC)
				pdout_next = {4'h0, sec_reg};
			else
				poe_next = 1'b0;
		end
		if (sfr_addr_in == SFR_CMD)
			sfr_rd_next = cmd_reg;
		else if (sfr_addr_in == SFR_DATA1)
			sfr_rd_next = edata_reg[7:0];
		else if (sfr_addr_in == SFR_DATA2)
			sfr_rd_next = edata_reg[15:8];
		else if (sfr_addr_in == SFR_DATA3)
			sfr_rd_next = edata_reg[23:16];
		else if (sfr_addr_in == SFR_DATA4)
			sfr_rd_next = edata_reg[31:24];
		else if (sfr_addr_in == SFR_ADDRL)
			sfr_rd_next = addr_l_reg;
		else if (sfr_addr_in == SFR_ADDRH)
			sfr_rd_next = addr_h_reg;
		else
			sfr_rd_next = 8'h00;
		// Code reads from external memory blocked only by secure
		code_rd_next = (core_ext_in && sec_reg[SEC_SECURE]) ? 8'h00
			: prog_rd(core_fetch_addr_in);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Flash arrays have no reset
	always_ff @(posedge mclk_in)
	begin
		if (pm_we)
			pmem[pm_wa] <= pm_wd;
		if (dm_we)
			dmem[dm_wa] <= dm_wd;
	end

	// Control state; security bits are nonvolatile and survive reset
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			st_reg <= ST_IDLE;
			er_addr_reg <= 16'h0000;
			er_end_reg <= 16'h0000;
			er_data_reg <= 1'b0;
			cmd_reg <= CMD_RESET;
			edata_reg <= 32'h00000000;
			addr_l_reg <= 8'h00;
			addr_h_reg <= 8'h00;
			user_download_mode_reg <= 1'b0;
			serdl_reg <= 1'b0;
			bootvec_reg <= RESET_ADDR;
			boot_cnt_reg <= 2'h0;
			pdout_reg <= 8'h00;
			poe_reg <= 1'b0;
			sfr_rd_reg <= 8'h00;
			code_rd_reg <= 8'h00;
			strb_prev_reg <= 1'b1;
			done_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			er_addr_reg <= er_addr_next;
			er_end_reg <= er_end_next;
			er_data_reg <= er_data_next;
			cmd_reg <= cmd_next;
			edata_reg <= edata_next;
			addr_l_reg <= addr_l_next;
			addr_h_reg <= addr_h_next;
			user_download_mode_reg <= user_download_mode_next;
			serdl_reg <= serdl_next;
			bootvec_reg <= bootvec_next;
			boot_cnt_reg <= boot_cnt_next;
			pdout_reg <= pdout_next;
			poe_reg <= poe_next;
			sfr_rd_reg <= sfr_rd_next;
			code_rd_reg <= code_rd_next;
			strb_prev_reg <= ws_s2;
			done_reg <= done_next;
			busy_reg <= busy_next;
		end
	end

	// Security bits: reset loads SEC_RESET only while they are still unknown after power-on
	always_ff @(posedge mclk_in)
	begin
		if (srst_in && boot_cnt_reg == 2'h0 && st_reg == ST_IDLE
			&& sec_reg === 4'hx)
			sec_reg <= SEC_RESET;
		else if (!srst_in)
			sec_reg <= sec_next;
	end

	// Outputs straight from flip-flops
	assign parallel_data_port_out = pdout_reg;
	assign parallel_data_port_oe_out = poe_reg;
	assign sfr_rdata_out = sfr_rd_reg;
	assign code_rdata_out = code_rd_reg;
	assign serial_download_out = serdl_reg;
	assign boot_vector_out = bootvec_reg;
	assign boot_done_out = done_reg;
	assign user_download_mode_out = user_download_mode_reg;
	assign flash_busy_out = busy_reg;
	assign sec_out = sec_reg;
endmodule
`default_nettype wire

/* File: test/fpa_checker_sva.sv */
// Port-level checker for the flash access and security block.
// Assumes one clock, mclk_in, and the synchronous reset srst_in.
`default_nettype none
module fpa_checker
	import fpa_pkg::*;
#(
	parameter logic [7:0] SIGNATURE = 8'h5a
)
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic boot_select_pin_n_in,
	input wire logic par_mode_in,
	input wire logic [3:0] par_op_select_in,
	input wire logic kern_wr_in,
	input wire logic kern_erase_in,
	input wire logic [2:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic core_ext_in,
	input wire logic [7:0] parallel_data_port_out,
	input wire logic parallel_data_port_oe_out,
	input wire logic [7:0] code_rdata_out,
	input wire logic serial_download_out,
	input wire logic [15:0] boot_vector_out,
	input wire logic boot_done_out,
	input wire logic user_download_mode_out,
	input wire logic flash_busy_out,
	input wire logic [3:0] sec_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);

	// Select code outside the decoded set
	wire unl = !(par_op_select_in inside {OP_ERASE, OP_SIG, OP_PCODE,
		OP_PDATA, OP_RCODE, OP_RDATA, OP_PSEC, OP_RSEC});

	// --------------------------------------------------------------
	// Steps and properties
	// --------------------------------------------------------------
	sequence boot_made;
		$rose(boot_done_out);
	endsequence
	sequence par_erase_end;
		flash_busy_out && par_mode_in && par_op_select_in == OP_ERASE
		##1 !flash_busy_out;
	endsequence
	sequence cmd_wr(logic [7:0] c);
		sfr_wr_in && sfr_addr_in == SFR_CMD && sfr_wdata_in == c &&
		!flash_busy_out && !par_mode_in && !kern_wr_in && !kern_erase_in;
	endsequence

	a_unlisted_quiet: assert property (unl [*5] |->
		!parallel_data_port_oe_out) else $error("unlisted code drives");
	a_idle_released: assert property (!par_mode_in [*5] |->
		!parallel_data_port_oe_out) else $error("data port driven");
	a_sig_value: assert property (
		(par_mode_in && par_op_select_in == OP_SIG) [*5] |->
		parallel_data_port_oe_out && parallel_data_port_out == SIGNATURE)
		else $error("signature read wrong");
	a_secure_blank: assert property ((par_mode_in &&
		par_op_select_in == OP_RCODE && sec_out[SEC_SECURE]) [*5] |->
		parallel_data_port_out == 8'h00) else $error("secure read leaks");
	a_ext_blocked: assert property (core_ext_in &&
		sec_out[SEC_SECURE] |=> code_rdata_out == 8'h00)
		else $error("external code read leaks");
	a_erase_clears: assert property (par_erase_end |->
		##[0:2] sec_out == SEC_RESET) else $error("erase kept locks");
	a_safe_normal: assert property (boot_made ##0
		sec_out[SEC_SAFE] |=> !serial_download_out)
		else $error("serial safe ignored");
	a_boot_entry: assert property (boot_made ##0 (!sec_out[SEC_SAFE] &&
		!boot_select_pin_n_in && !$past(boot_select_pin_n_in, 4)) |=>
		serial_download_out) else $error("no serial download entry");
	a_vector_pick: assert property (boot_made |=> boot_vector_out ==
		(sec_out[SEC_BOOT] ? BOOT_ADDR : RESET_ADDR))
		else $error("boot vector wrong");
	a_user_download_mode_enter: assert property (cmd_wr(CMD_USER_DOWNLOAD_MODE) |=>
		user_download_mode_out) else $error("user mode not entered");
	a_user_download_mode_leave: assert property (cmd_wr(CMD_LEAVE_USER_DOWNLOAD_MODE) |=>
		!user_download_mode_out) else $error("user mode not left");
endmodule

bind fpa_top fpa_checker #(.SIGNATURE(SIGNATURE)) i_fpa_checker (
	.mclk_in(mclk_in), .srst_in(srst_in),
	.boot_select_pin_n_in(boot_select_pin_n_in),
	.par_mode_in(par_mode_in), .par_op_select_in(par_op_select_in),
	.kern_wr_in(kern_wr_in), .kern_erase_in(kern_erase_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
	.sfr_wdata_in(sfr_wdata_in), .core_ext_in(core_ext_in),
	.parallel_data_port_out(parallel_data_port_out),
	.parallel_data_port_oe_out(parallel_data_port_oe_out),
	.code_rdata_out(code_rdata_out),
	.serial_download_out(serial_download_out),
	.boot_vector_out(boot_vector_out), .boot_done_out(boot_done_out),
	.user_download_mode_out(user_download_mode_out),
	.flash_busy_out(flash_busy_out), .sec_out(sec_out)
);
`default_nettype wire

/* File: test/fpa_prog_model.sv */
// Behavioural parallel programmer: address, data, strobe and select pins.
// Assumes the device samples its pins through synchronisers.
`default_nettype none
module fpa_prog_model
	import fpa_pkg::*;
(
	input wire logic mclk_in,
	output logic par_mode_out,
	output logic [15:0] par_addr_out,
	output logic [7:0] par_data_out,
	output logic par_data_en_out,
	output logic write_strobe_n_out,
	output logic [3:0] op_select_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins idle, strobe high
	initial
	begin
		par_mode_out = 1'b0;
		par_addr_out = 16'h0000;
		par_data_out = 8'h00;
		par_data_en_out = 1'b0;
		write_strobe_n_out = 1'b1;
		op_select_out = 4'hf;
	end

	task tick;
		@(posedge mclk_in);
		#1;
	endtask

	task mode(input logic m);
		par_mode_out = m;
		repeat (4) tick;
	endtask

	// Setup held for gap cycles, then a strobe pulse, then hold
	task pwrite(input logic [3:0] op, input logic [15:0] a,
		input logic [7:0] d, input int gap);
		op_select_out = op;
		par_addr_out = a;
		par_data_out = d;
		par_data_en_out = 1'b1;
		repeat (gap) tick;
		write_strobe_n_out = 1'b0;
		repeat (4) tick;
		write_strobe_n_out = 1'b1;
		repeat (4) tick;
		par_data_en_out = 1'b0;
		tick;
	endtask

	// Bus released, address and select held while the device answers
	task pread(input logic [3:0] op, input logic [15:0] a);
		op_select_out = op;
		par_addr_out = a;
		repeat (6) tick;
	endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench: serial download, parallel programming, locks
// and the page register interface. Assumes the programmer model.
`default_nettype none
module tb_top;
	import fpa_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SIG = 8'h5a; // Arbitrary signature value
	logic clk = 1'b0, srst = 1'b1, boot_n = 1'b0, kwr = 1'b0, kerase = 1'b0;
	logic ksw = 1'b0, sfr_wr = 1'b0, ext = 1'b0;
	logic [3:0] ksec_v = 4'h0;
	logic [15:0] kaddr = 16'h0000, fetch = 16'h0000;
	logic [7:0] kdata = 8'h00, wdata = 8'h00;
	logic [2:0] sfr_a = 3'h0;
	logic [7:0] pg [4] = '{8'h11, 8'h5c, 8'h33, 8'h44};
	wire pmode, pen, strobe_n, oe, serial, bdone, user_download_mode, busy;
	wire [15:0] paddr, bvec;
	wire [7:0] pd, dout, sfr_rd, code_rd;
	wire [3:0] op, sec;
	int errors = 0, checks = 0;
	// Released data lines show the inverse of the last value
	wire [7:0] pwire = oe ? dout : (pen ? pd : ~pd);

	always #4 clk = ~clk;

	fpa_prog_model i_fpa_prog_model (.mclk_in(clk), .par_mode_out(pmode),
		.par_addr_out(paddr), .par_data_out(pd), .par_data_en_out(pen),
		.write_strobe_n_out(strobe_n), .op_select_out(op));
	fpa_top #(.SIGNATURE(SIG)) i_fpa_top (.mclk_in(clk), .srst_in(srst),
		.boot_select_pin_n_in(boot_n), .par_mode_in(pmode),
		.par_addr_in(paddr), .parallel_data_port_in(pwire),
		.parallel_write_strobe_n_in(strobe_n), .par_op_select_in(op),
		.kern_wr_in(kwr), .kern_addr_in(kaddr), .kern_data_in(kdata),
		.kern_erase_in(kerase), .kern_sec_wr_in(ksw), .kern_sec_in(ksec_v),
		.sfr_addr_in(sfr_a), .sfr_wr_in(sfr_wr), .sfr_wdata_in(wdata),
		.core_fetch_addr_in(fetch), .core_ext_in(ext),
		.parallel_data_port_out(dout), .parallel_data_port_oe_out(oe),
		.sfr_rdata_out(sfr_rd), .code_rdata_out(code_rd),
		.serial_download_out(serial), .boot_vector_out(bvec),
		.boot_done_out(bdone), .user_download_mode_out(user_download_mode),
		.flash_busy_out(busy), .sec_out(sec));

	// --------------------------------------------------------------
	// Access tasks
	// --------------------------------------------------------------
	task tick;
		@(posedge clk);
		#1;
	endtask
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Bounded wait for boot done or for the erase engine to go idle
	task waitf(input bit boot, input int lim);
		int i;
		i = 0;
		while ((boot ? bdone : !busy) !== 1'b1 && i < lim)
		begin
			tick;
			i++;
		end
		if (i >= lim)
		begin
			errors++;
			wrap_up;
		end
	endtask
	task rst(input logic pin);
		boot_n = pin;
		srst = 1'b1;
		repeat (5) tick;
		srst = 1'b0;
		waitf(1, 20);
		tick;
	endtask
	task kw(input logic [15:0] a, input logic [7:0] d);
		kaddr = a;
		kdata = d;
		kwr = 1'b1;
		tick;
		kwr = 1'b0;
		tick;
	endtask
	task cread(input logic [15:0] a, input logic e, input logic [7:0] x);
		fetch = a;
		ext = e;
		tick;
		cmp(code_rd, x);
	endtask
	task sw(input logic [2:0] a, input logic [7:0] d);
		sfr_a = a;
		wdata = d;
		sfr_wr = 1'b1;
		tick;
		sfr_wr = 1'b0;
		tick;
	endtask
	task sr(input logic [2:0] a, input logic [7:0] x);
		sfr_a = a;
		repeat (2) tick;
		cmp(sfr_rd, x);
	endtask
	task pw(input logic [3:0] o, input logic [15:0] a, input logic [7:0] d);
		i_fpa_prog_model.pwrite(o, a, d, 4);
	endtask
	task pchk(input logic [3:0] o, input logic [15:0] a, input logic [8:0] x);
		i_fpa_prog_model.pread(o, a);
		cmp({oe, dout}, x);
	endtask

	// --------------------------------------------------------------
	// Test sequence
	// --------------------------------------------------------------
	initial
	begin
		rst(1'b0);
		cmp(serial, 1'b1);
		kw(16'h0010, 8'h3c);
		kw(16'he000, 8'h96);
		cread(16'h0010, 1'b0, 8'h3c);
		cread(16'he000, 1'b0, 8'h96);
		ksec_v = 4'h9;
		ksw = 1'b1;
		tick;
		ksw = 1'b0;
		tick;
		cmp(sec, 4'h9);
		$display("test serial download finished");
		i_fpa_prog_model.mode(1'b1);
		pw(OP_PCODE, 16'h0010, 8'h00);
		pchk(OP_RCODE, 16'h0010, 9'h13c);
		cread(16'h0010, 1'b1, 8'h3c);
		pw(OP_PSEC, 16'h0000, 8'h06);
		cmp(sec, 4'hf);
		pchk(OP_RCODE, 16'h0010, 9'h100);
		cread(16'h0010, 1'b1, 8'h00);
		pchk(OP_RSEC, 16'h0000, 9'h10f);
		pchk(OP_SIG, 16'h0000, {1'b1, SIG});
		i_fpa_prog_model.pread(4'h5, 16'h0000);
		cmp(oe, 1'b0);
		i_fpa_prog_model.mode(1'b0);
		$display("test locks finished");
		rst(1'b0);
		cmp(serial, 1'b0);
		cmp(bvec, BOOT_ADDR);
		kw(16'h0010, 8'h00);
		cread(16'h0010, 1'b0, 8'h3c);
		i_fpa_prog_model.mode(1'b1);
		pw(OP_ERASE, 16'h0000, 8'h00);
		waitf(0, 70000);
		cmp(sec, SEC_RESET);
		pchk(OP_RCODE, 16'h0010, 9'h1ff);
		i_fpa_prog_model.pwrite(OP_PCODE, 16'h0020, 8'ha5, 9);
		pchk(OP_RCODE, 16'h0020, 9'h1a5);
		pw(4'h7, 16'h0020, 8'h00);
		pchk(OP_RCODE, 16'h0020, 9'h1a5);
		pw(OP_PDATA, 16'h0ffd, 8'h5c);
		pchk(OP_RDATA, 16'h0ffd, 9'h15c);
		i_fpa_prog_model.mode(1'b0);
		$display("test parallel finished");
		rst(1'b1);
		cmp(serial, 1'b0);
		cmp(bvec, RESET_ADDR);
		sw(SFR_ADDRH, 8'h03);
		sw(SFR_ADDRL, 8'hff);
		sw(SFR_CMD, CMD_READ);
		sr(SFR_DATA2, 8'h5c);
		sr(SFR_DATA1, ERASED);
		sw(SFR_CMD, CMD_ERPAGE);
		for (int i = 0; i < 4; i++)
			sw(SFR_DATA1 + 3'(i), pg[i]);
		sw(SFR_CMD, CMD_WRITE);
		sw(SFR_CMD, CMD_VERIFY);
		sr(SFR_CMD, 8'h00);
		sw(SFR_DATA3, 8'h00);
		sw(SFR_CMD, CMD_VERIFY);
		sr(SFR_CMD, VERIFY_BAD);
		sw(SFR_CMD, CMD_READ);
		for (int i = 0; i < 4; i++)
			sr(SFR_DATA1 + 3'(i), pg[i]);
		sr(3'h7, 8'h00);
		sw(SFR_CMD, CMD_USER_DOWNLOAD_MODE);
		cmp(user_download_mode, 1'b1);
		sw(SFR_ADDRH, 8'h00);
		sw(SFR_ADDRL, 8'h40);
		sw(SFR_DATA1, 8'hc3);
		sw(SFR_CMD, CMD_WRBYTE);
		cread(16'h0040, 1'b0, 8'hc3);
		sw(SFR_CMD, CMD_ERPAGE);
		waitf(0, 5000);
		cread(16'h0040, 1'b0, ERASED);
		sw(SFR_ADDRH, 8'he0);
		sw(SFR_ADDRL, 8'h10);
		sw(SFR_CMD, CMD_WRBYTE);
		cread(16'he010, 1'b0, ERASED);
		sw(SFR_CMD, CMD_LEAVE_USER_DOWNLOAD_MODE);
		cmp(user_download_mode, 1'b0);
		sw(SFR_ADDRH, 8'h00);
		sw(SFR_ADDRL, 8'h41);
		sw(SFR_CMD, CMD_WRBYTE);
		cread(16'h0041, 1'b0, ERASED);
		sw(SFR_DATA1, 8'h00);
		sw(SFR_CMD, CMD_RDBYTE);
		sr(SFR_DATA1, 8'hc3);
		sw(SFR_CMD, CMD_ERALL);
		waitf(0, 2000);
		sw(SFR_CMD, CMD_RDBYTE);
		sr(SFR_DATA1, ERASED);
		$display("test registers finished");
		wrap_up;
	end
endmodule
`default_nettype wire
